// ---- rtl/nand_feature_map.vh ----
// Command codes, feature addresses, field positions and timing counts
`ifndef NAND_FEATURE_MAP_VH
`define NAND_FEATURE_MAP_VH

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define CMD_GET_FEATURES 8'h0F
`define CMD_SET_FEATURES 8'h1F
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_PAGE_READ 8'h13
`define CMD_PROGRAM_EXEC 8'h10
`define CMD_BLOCK_ERASE 8'hD8
`define CMD_SOFT_RESET 8'hFF

// ----------------------------------------------------------------------
// Feature addresses
// ----------------------------------------------------------------------
`define FA_PROTECTION 8'hA0
`define FA_ECC_QUAD_CFG 8'hB0
`define FA_PRIMARY_STATUS 8'hC0
`define FA_OUTPUT_DRIVE 8'hD0
`define FA_SECONDARY_STATUS 8'hF0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFG_ECC_ON_BIT 4
`define CFG_QUAD_BIT 0
`define DRV_LEVEL_MSB 6
`define DRV_LEVEL_LSB 5
`define ST1_BUSY_BIT 0
`define ST1_WPL_BIT 1
`define ST1_EFAIL_BIT 2
`define ST1_PFAIL_BIT 3
`define ST_ECC_MSB 5
`define ST_ECC_LSB 4
`define ST2_CACHE_BIT 0
`define ST2_LOCKED_BIT 3

// ----------------------------------------------------------------------
// Reset values, ECC encodings, operation kinds
// ----------------------------------------------------------------------
`define ECC_ON_RESET 1'b1
`define QUAD_RESET 1'b0
`define DRIVE_RESET 2'h0
`define LOCKED_RESET 1'b1
`define ECC_NONE 2'h0
`define ECC_CORRECTED 2'h1
`define ECC_UNCORRECTED 2'h2
`define OP_READ 2'h0
`define OP_PROGRAM 2'h1
`define OP_ERASE 2'h2

// ----------------------------------------------------------------------
// Timing: soft-reset busy time (arbitrary figure)
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define SOFT_RESET_BUSY_NS 500
`define SOFT_RESET_BUSY_CYCLES (`SOFT_RESET_BUSY_NS / `CLK_PERIOD_NS)

`endif

// ---- rtl/nand_feature_regs.v ----
// Serial NAND status, configuration and drive-strength feature registers
`timescale 1ns/1ps
`include "nand_feature_map.vh"

module nand_feature_regs #(
  parameter RST_BUSY_CYCLES = `SOFT_RESET_BUSY_CYCLES
) (
  input wire clk_i, // System clock, 100 MHz
  input wire srst_i, // Synchronous power-on reset, active high
  input wire sclk_i, // Serial clock pin from host
  input wire cs_n_i, // Chip select pin, active low
  input wire mosi_i, // Serial data in pin
  output wire miso_o, // Serial data out
  output wire miso_oe_o, // Serial data out enable
  input wire region_locked_i, // Addressed block is protected
  input wire block_locked_i, // Selected block protection status
  input wire cache_busy_i, // Cache unavailable
  input wire array_done_i, // Array operation finished, pulse
  input wire array_fail_i, // Program or erase failed, with done
  input wire [2:0] ecc_bits_i, // Corrected bit count, with done
  input wire ecc_uncorr_i, // Uncorrectable read, with done
  output wire op_start_o, // Start array operation, pulse
  output wire [1:0] op_kind_o, // Operation kind for op_start_o
  output wire ecc_on_o, // Internal ECC enabled
  output wire quad_io_permit_o, // Quad IO operations allowed
  output wire [1:0] drive_level_o, // Output drive strength select
  output wire operation_busy_o // Device busy
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  reg sclk_s1_reg;
  reg sclk_s2_reg;
  reg sclk_s3_reg;
  reg cs_n_s1_reg;
  reg cs_n_s2_reg;
  reg cs_n_s3_reg;
  reg mosi_s1_reg;
  reg mosi_s2_reg;

  // No reset: tracking the pins through reset avoids a false edge after it
  always @(posedge clk_i) begin
    sclk_s1_reg <= sclk_i;
    sclk_s2_reg <= sclk_s1_reg;
    sclk_s3_reg <= sclk_s2_reg;
    cs_n_s1_reg <= cs_n_i;
    cs_n_s2_reg <= cs_n_s1_reg;
    cs_n_s3_reg <= cs_n_s2_reg;
    mosi_s1_reg <= mosi_i;
    mosi_s2_reg <= mosi_s1_reg;
  end

  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  wire frame_end = cs_n_s2_reg & ~cs_n_s3_reg;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [2:0] bit_cnt_reg;
  reg [1:0] byte_cnt_reg;
  reg [6:0] shift_reg;
  reg [7:0] cmd_reg;
  reg [7:0] addr_reg;
  reg cmd_valid_reg;
  reg [7:0] out_reg;
  reg out_active_reg;
  reg miso_reg;
  reg miso_oe_reg;
  reg ecc_on_reg;
  reg quad_reg;
  reg [1:0] drive_reg;
  reg [1:0] ecc_summary_reg;
  reg [1:0] ecc_count_ext_reg;
  reg program_failed_reg;
  reg erase_failed_reg;
  reg write_permit_latch_reg;
  reg array_active_reg;
  reg [1:0] active_kind_reg;
  reg boot_read_reg;
  reg [15:0] rst_cnt_reg;
  reg busy_reg;
  reg locked_reg;
  reg cache_busy_reg;
  reg op_start_reg;
  reg [1:0] op_kind_reg;

  wire [7:0] byte_in = {shift_reg, mosi_s2_reg};
  wire [7:0] rd_addr = (byte_cnt_reg == 2'h1) ? byte_in : addr_reg;
  reg [7:0] rd_data;

  // --------------------------------------------------------------------
  // Feature read mux
  // --------------------------------------------------------------------
  always @* begin
    rd_data = 8'h00;
    case (rd_addr)
      `FA_ECC_QUAD_CFG: begin
        rd_data[`CFG_ECC_ON_BIT] = ecc_on_reg;
        rd_data[`CFG_QUAD_BIT] = quad_reg;
      end
      `FA_PRIMARY_STATUS: begin
        rd_data[`ST1_BUSY_BIT] = busy_reg;
        rd_data[`ST1_WPL_BIT] = write_permit_latch_reg;
        rd_data[`ST1_EFAIL_BIT] = erase_failed_reg;
        rd_data[`ST1_PFAIL_BIT] = program_failed_reg;
        rd_data[`ST_ECC_MSB:`ST_ECC_LSB] = ecc_summary_reg;
      end
      `FA_OUTPUT_DRIVE: begin
        rd_data[`DRV_LEVEL_MSB:`DRV_LEVEL_LSB] = drive_reg;
      end
      `FA_SECONDARY_STATUS: begin
        rd_data[`ST2_CACHE_BIT] = cache_busy_reg;
        rd_data[`ST2_LOCKED_BIT] = locked_reg;
        rd_data[`ST_ECC_MSB:`ST_ECC_LSB] = ecc_count_ext_reg;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Serial frame engine and feature registers
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      shift_reg <= 7'h00;
      cmd_reg <= 8'h00;
      addr_reg <= 8'h00;
      cmd_valid_reg <= 1'b0;
      out_reg <= 8'h00;
      out_active_reg <= 1'b0;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      ecc_on_reg <= `ECC_ON_RESET;
      quad_reg <= `QUAD_RESET;
      drive_reg <= `DRIVE_RESET;
      ecc_summary_reg <= `ECC_NONE;
      ecc_count_ext_reg <= 2'h0;
      program_failed_reg <= 1'b0;
      erase_failed_reg <= 1'b0;
      write_permit_latch_reg <= 1'b0;
      array_active_reg <= 1'b1; // Boot read pending, keeps busy up
      active_kind_reg <= `OP_READ;
      boot_read_reg <= 1'b1;
      rst_cnt_reg <= 16'h0000;
      busy_reg <= 1'b1;
      locked_reg <= `LOCKED_RESET;
      cache_busy_reg <= 1'b0;
      op_start_reg <= 1'b0;
      op_kind_reg <= `OP_READ;
    end else begin
      op_start_reg <= 1'b0;
      locked_reg <= block_locked_i;
      cache_busy_reg <= cache_busy_i;
      busy_reg <= array_active_reg | (rst_cnt_reg != 16'h0000);
      if (rst_cnt_reg != 16'h0000) begin
        rst_cnt_reg <= rst_cnt_reg - 16'h0001;
      end
      // Power-on loads ECC status from block 0 page 0
      if (boot_read_reg) begin
        boot_read_reg <= 1'b0;
        array_active_reg <= 1'b1;
        active_kind_reg <= `OP_READ;
        op_start_reg <= 1'b1;
        op_kind_reg <= `OP_READ;
      end
      if (cs_n_s2_reg) begin
        bit_cnt_reg <= 3'h0;
        byte_cnt_reg <= 2'h0;
        out_active_reg <= 1'b0;
        miso_oe_reg <= 1'b0;
      end else if (sclk_rise) begin
        shift_reg <= byte_in[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          if (byte_cnt_reg != 2'h3) begin
            byte_cnt_reg <= byte_cnt_reg + 2'h1;
          end
          if (byte_cnt_reg == 2'h0) begin
            cmd_reg <= byte_in;
            cmd_valid_reg <= 1'b1;
          end
          if (byte_cnt_reg == 2'h1) begin
            addr_reg <= byte_in;
          end
          // Reloading each byte lets the host poll status in one frame
          if (cmd_reg == `CMD_GET_FEATURES && byte_cnt_reg != 2'h0) begin
            out_reg <= rd_data;
            out_active_reg <= 1'b1;
          end
          if (cmd_reg == `CMD_SET_FEATURES && byte_cnt_reg == 2'h2) begin
            case (addr_reg)
              `FA_ECC_QUAD_CFG: begin
                ecc_on_reg <= byte_in[`CFG_ECC_ON_BIT];
                quad_reg <= byte_in[`CFG_QUAD_BIT];
              end
              `FA_OUTPUT_DRIVE: begin
                drive_reg <= byte_in[`DRV_LEVEL_MSB:`DRV_LEVEL_LSB];
              end
              default: ; // Status registers are read-only; writes dropped
            endcase
          end
        end
      end else if (sclk_fall && out_active_reg) begin
        miso_reg <= out_reg[7];
        out_reg <= {out_reg[6:0], 1'b0};
        miso_oe_reg <= 1'b1;
      end

      // Commands act when chip select rises
      if (frame_end && cmd_valid_reg) begin
        cmd_valid_reg <= 1'b0;
        case (cmd_reg)
          `CMD_WRITE_ENABLE: write_permit_latch_reg <= 1'b1;
          `CMD_WRITE_DISABLE: write_permit_latch_reg <= 1'b0;
          `CMD_PAGE_READ: begin
            if (!busy_reg) begin
              ecc_summary_reg <= `ECC_NONE;
              ecc_count_ext_reg <= 2'h0;
              array_active_reg <= 1'b1;
              active_kind_reg <= `OP_READ;
              op_start_reg <= 1'b1;
              op_kind_reg <= `OP_READ;
            end
          end
          `CMD_PROGRAM_EXEC: begin
            if (!busy_reg && write_permit_latch_reg) begin
              // Locked target fails at once and never shows busy
              program_failed_reg <= region_locked_i;
              if (!region_locked_i) begin
                array_active_reg <= 1'b1;
                active_kind_reg <= `OP_PROGRAM;
                op_start_reg <= 1'b1;
                op_kind_reg <= `OP_PROGRAM;
              end
            end
          end
          `CMD_BLOCK_ERASE: begin
            if (!busy_reg && write_permit_latch_reg) begin
              erase_failed_reg <= region_locked_i;
              if (!region_locked_i) begin
                array_active_reg <= 1'b1;
                active_kind_reg <= `OP_ERASE;
                op_start_reg <= 1'b1;
                op_kind_reg <= `OP_ERASE;
              end
            end
          end
          `CMD_SOFT_RESET: begin
            // Config and drive keep their values across this reset
            ecc_summary_reg <= `ECC_NONE;
            ecc_count_ext_reg <= 2'h0;
            program_failed_reg <= 1'b0;
            erase_failed_reg <= 1'b0;
            write_permit_latch_reg <= 1'b0;
            array_active_reg <= 1'b0;
            boot_read_reg <= 1'b0;
            rst_cnt_reg <= RST_BUSY_CYCLES[15:0];
          end
          default: ;
        endcase
      end

      // Completion comes last so a result set wins over a same-cycle clear, unless that clear is a soft reset, which skips completion
      if (array_done_i && array_active_reg &&
          !(frame_end && cmd_valid_reg && cmd_reg == `CMD_SOFT_RESET)) begin
        array_active_reg <= 1'b0;
        case (active_kind_reg)
          `OP_READ: begin
            // Fields are left clear when ECC is off; host must ignore them
            if (ecc_on_reg) begin
              if (ecc_uncorr_i || ecc_bits_i > 3'h4) begin
                ecc_summary_reg <= `ECC_UNCORRECTED;
                ecc_count_ext_reg <= 2'h0;
              end else if (ecc_bits_i == 3'h0) begin
                ecc_summary_reg <= `ECC_NONE;
                ecc_count_ext_reg <= 2'h0;
              end else begin
                ecc_summary_reg <= `ECC_CORRECTED;
                ecc_count_ext_reg <= ecc_bits_i[1:0] - 2'h1;
              end
            end
          end
          `OP_PROGRAM: begin
            if (array_fail_i) begin
              program_failed_reg <= 1'b1;
            end
          end
          `OP_ERASE: begin
            if (array_fail_i) begin
              erase_failed_reg <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign miso_o = miso_reg;
  assign miso_oe_o = miso_oe_reg;
  assign op_start_o = op_start_reg;
  assign op_kind_o = op_kind_reg;
  assign ecc_on_o = ecc_on_reg;
  assign quad_io_permit_o = quad_reg;
  assign drive_level_o = drive_reg;
  assign operation_busy_o = busy_reg;

endmodule // nand_feature_regs

// ---- verification/feature_regs_assertions.sv ----
// Port-level concurrent checks for the feature register block
`timescale 1ns/1ps
`include "nand_feature_map.vh"
module feature_regs_checker (
  input wire clk_i, // System clock
  input wire srst_i, // Sync reset
  input wire cs_n_i, // Chip select pin
  input wire array_done_i, // Array done pulse
  input wire miso_oe_o, // Serial out enable
  input wire op_start_o, // Array start pulse
  input wire [1:0] op_kind_o, // Operation kind
  input wire ecc_on_o, // ECC enable
  input wire quad_io_permit_o, // Quad permit
  input wire [1:0] drive_level_o, // Drive strength
  input wire operation_busy_o // Busy flag
);
  // ---
  // Checks
  // ---
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  AST_RST_VAL: assert property (disable iff (1'b0)
    srst_i |=> ecc_on_o && !quad_io_permit_o && drive_level_o == 2'h0
    && operation_busy_o && !op_start_o) else $error("bad reset state");
  AST_BOOT_READ: assert property (
    $fell(srst_i) |-> ##[0:2] (op_start_o && op_kind_o == `OP_READ))
    else $error("no boot read");
  AST_START_PULSE: assert property (
    op_start_o |=> !op_start_o) else $error("start not a pulse");
  AST_BUSY_ON_START: assert property (
    op_start_o |=> operation_busy_o) else $error("busy missing");
  AST_BUSY_ENDS: assert property (
    array_done_i && operation_busy_o |-> ##[1:2] !operation_busy_o)
    else $error("busy stuck after done");
  AST_START_IDLE: assert property (
    op_start_o |-> cs_n_i) else $error("start inside frame");
  AST_KIND_HOLD: assert property (
    !op_start_o && !$past(srst_i) |-> $stable(op_kind_o))
    else $error("kind changed without start");
  AST_CFG_HOLD: assert property (
    cs_n_i [*8] |=> $stable({ecc_on_o, quad_io_permit_o, drive_level_o}))
    else $error("config changed between frames");
  AST_OE_IDLE: assert property (
    cs_n_i [*6] |-> !miso_oe_o) else $error("miso driven when idle");
endmodule // feature_regs_checker

bind nand_feature_regs feature_regs_checker CHK (
  .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i),
  .array_done_i(array_done_i), .miso_oe_o(miso_oe_o),
  .op_start_o(op_start_o), .op_kind_o(op_kind_o), .ecc_on_o(ecc_on_o),
  .quad_io_permit_o(quad_io_permit_o), .drive_level_o(drive_level_o),
  .operation_busy_o(operation_busy_o));

// ---- verification/host_model.sv ----
// Host serial controller model: mode 0 frames, 80 ns link clock
`timescale 1ns/1ps
module host_model (
  output logic sclk_o, // Serial clock, idle low
  output logic cs_n_o, // Chip select, active low
  output logic mosi_o, // Serial data to device
  input wire logic miso_i, // Serial data from device
  input wire logic miso_oe_i // Device drives miso
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Sends nb bytes msb first, then clocks one byte back when rd is set
  task automatic frame(input logic [23:0] tx, input int nb, input bit rd,
                       output logic [7:0] rx);
    int i;
    cs_n_o = 1'b0;
    for (i = 0; i < nb * 8 + (rd ? 8 : 0); i++) begin
      // Unused line toggles so a stale level is never mistaken for data
      mosi_o = (i < nb * 8) ? tx[23 - i] : ~mosi_o;
      #40 sclk_o = 1'b1;
      // Late sample: miso moves only after the falling edge
      #35;
      // A released line reads inverted so a missing enable shows up
      if (i >= nb * 8)
        rx = {rx[6:0], miso_oe_i ? miso_i : ~miso_i};
      #5 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #100;
  endtask
endmodule // host_model

// ---- verification/serial_nand_status_feature_regs_test.sv ----
// Self-checking bench for the feature register block
`timescale 1ns/1ps
`include "nand_feature_map.vh"
`define CHECK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module serial_nand_status_feature_regs_test;
  logic clk_i, srst_i, region_locked_i, block_locked_i, cache_busy_i;
  logic array_done_i = 1'b0, array_fail_i = 1'b0, ecc_uncorr_i = 1'b0;
  logic r_fail, r_unc, saw_busy;
  logic [2:0] ecc_bits_i = 3'h0, r_bits;
  logic [1:0] r_kind;
  logic [7:0] v, e;
  wire sclk, cs_n, mosi, miso, miso_oe, op_start_o, ecc_on_o;
  wire quad_io_permit_o, operation_busy_o;
  wire [1:0] op_kind_o, drive_level_o;
  wire [3:0] cfg = {ecc_on_o, quad_io_permit_o, drive_level_o};
  int n_errors = 0, checks = 0, r_dly = 5, k;

  nand_feature_regs #(.RST_BUSY_CYCLES(4)) DUT (
    .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .region_locked_i(region_locked_i), .block_locked_i(block_locked_i),
    .cache_busy_i(cache_busy_i), .array_done_i(array_done_i),
    .array_fail_i(array_fail_i), .ecc_bits_i(ecc_bits_i),
    .ecc_uncorr_i(ecc_uncorr_i), .op_start_o(op_start_o),
    .op_kind_o(op_kind_o), .ecc_on_o(ecc_on_o),
    .quad_io_permit_o(quad_io_permit_o), .drive_level_o(drive_level_o),
    .operation_busy_o(operation_busy_o));
  host_model HOST (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ---
  // Array model: completes each started operation after r_dly cycles
  // ---
  always @(negedge clk_i) begin
    if (op_start_o === 1'b1) begin
      r_kind = op_kind_o;
      repeat (r_dly) @(negedge clk_i);
      array_done_i = 1'b1;
      array_fail_i = r_fail;
      ecc_bits_i = r_bits;
      ecc_uncorr_i = r_unc;
      @(negedge clk_i);
      array_done_i = 1'b0;
    end
    if (operation_busy_o === 1'b1)
      saw_busy = 1'b1;
  end

  // ---
  // Access tasks
  // ---
  task automatic xfer(input logic [23:0] tx, input int nb, input bit rd);
    HOST.frame(tx, nb, rd, v);
    @(negedge clk_i);
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] x);
    xfer({`CMD_GET_FEATURES, a, 8'h00}, 2, 1'b1);
    `CHECK(v, x)
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    xfer({`CMD_SET_FEATURES, a, d}, 3, 1'b0);
  endtask
  task automatic cmd(input logic [7:0] c);
    xfer({c, 16'h0000}, 1, 1'b0);
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 1000 && operation_busy_o !== 1'b0; i++)
      @(negedge clk_i);
    if (i == 1000) begin
      $display("[FAIL] %0t busy never fell", $time);
      n_errors++;
      conclude();
    end
  endtask
  task automatic conclude;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ---
  // Main sequence
  // ---
  initial begin
    srst_i = 1'b1;
    {region_locked_i, cache_busy_i} = 2'h0;
    {r_fail, r_unc, saw_busy} = 3'h0;
    block_locked_i = 1'b1;
    r_bits = 3'h2;
    repeat (6) @(negedge clk_i);
    `CHECK(cfg, 4'h8)
    srst_i = 1'b0;
    wait_idle;
    expect_reg(`FA_PRIMARY_STATUS, 8'h10);
    expect_reg(`FA_SECONDARY_STATUS, 8'h18);
    {block_locked_i, cache_busy_i} = 2'b01;
    expect_reg(`FA_SECONDARY_STATUS, 8'h11);
    cache_busy_i = 1'b0;
    for (k = 0; k < 6; k++) begin
      r_bits = (k < 5) ? k[2:0] : 3'h0;
      r_unc = (k == 5);
      cmd(`CMD_PAGE_READ);
      wait_idle;
      e = (k == 0) ? 8'h00 : (k < 5) ? 8'h10 : 8'h20;
      expect_reg(`FA_PRIMARY_STATUS, e);
      e = {2'b00, k[1:0] - 2'h1, 4'h0};
      if (k > 0 && k < 5)
        expect_reg(`FA_SECONDARY_STATUS, e);
    end
    // Long read so the status can be polled mid-operation
    {r_bits, r_unc, r_dly} = {3'h3, 1'b0, 32'd400};
    cmd(`CMD_PAGE_READ);
    expect_reg(`FA_PRIMARY_STATUS, 8'h01);
    wait_idle;
    r_dly = 5;
    put(`FA_PRIMARY_STATUS, 8'h3F);
    put(`FA_SECONDARY_STATUS, 8'h39);
    expect_reg(`FA_PRIMARY_STATUS, 8'h10);
    expect_reg(`FA_SECONDARY_STATUS, 8'h20);
    put(`FA_ECC_QUAD_CFG, 8'h01);
    `CHECK(cfg, 4'h4)
    expect_reg(`FA_ECC_QUAD_CFG, 8'h01);
    // ECC off: a read leaves the result fields clear
    cmd(`CMD_PAGE_READ);
    wait_idle;
    expect_reg(`FA_PRIMARY_STATUS, 8'h00);
    put(`FA_ECC_QUAD_CFG, 8'h10);
    `CHECK(cfg, 4'h8)
    cmd(`CMD_PAGE_READ);
    wait_idle;
    expect_reg(`FA_PRIMARY_STATUS, 8'h10);
    for (k = 0; k < 4; k++) begin
      put(`FA_OUTPUT_DRIVE, {1'b0, k[1:0], 5'h00});
      `CHECK(drive_level_o, k[1:0])
      expect_reg(`FA_OUTPUT_DRIVE, {1'b0, k[1:0], 5'h00});
    end
    r_fail = 1'b1;
    cmd(`CMD_PROGRAM_EXEC);
    expect_reg(`FA_PRIMARY_STATUS, 8'h10);
    cmd(`CMD_WRITE_ENABLE);
    expect_reg(`FA_PRIMARY_STATUS, 8'h12);
    cmd(`CMD_PROGRAM_EXEC);
    wait_idle;
    expect_reg(`FA_PRIMARY_STATUS, 8'h1A);
    `CHECK(r_kind, `OP_PROGRAM)
    region_locked_i = 1'b1;
    cmd(`CMD_BLOCK_ERASE);
    expect_reg(`FA_PRIMARY_STATUS, 8'h1E);
    {region_locked_i, r_fail} = 2'b00;
    cmd(`CMD_BLOCK_ERASE);
    wait_idle;
    expect_reg(`FA_PRIMARY_STATUS, 8'h1A);
    `CHECK(r_kind, `OP_ERASE)
    cmd(`CMD_PROGRAM_EXEC);
    wait_idle;
    expect_reg(`FA_PRIMARY_STATUS, 8'h12);
    r_fail = 1'b1;
    cmd(`CMD_PROGRAM_EXEC);
    wait_idle;
    cmd(`CMD_WRITE_DISABLE);
    expect_reg(`FA_PRIMARY_STATUS, 8'h18);
    saw_busy = 1'b0;
    cmd(`CMD_SOFT_RESET);
    wait_idle;
    `CHECK(saw_busy, 1'b1)
    `CHECK(cfg, 4'hB)
    expect_reg(`FA_PRIMARY_STATUS, 8'h00);
    conclude();
  end
endmodule // serial_nand_status_feature_regs_test
